/* File: hw/zas_pkg.sv */
// package: constants, register map and carrier types for the zone alarm supervisor
package zas_pkg;
  // ----------------------------------------
  // geometry and timing
  // ----------------------------------------
  localparam int ZONES = 8;
  localparam int TW = 10;
  localparam int CLK_HZ = 250_000_000;
  localparam int SECOND_CYCLES = CLK_HZ;
  localparam logic [6:0] DELAY_MAX_S = 7'h5A;
  localparam int WDOG_CYCLES = 1_000_000;

  // ----------------------------------------
  // reset values and limits
  // ----------------------------------------
  localparam logic [TW-1:0] LOW_THR_RST = 10'h000;
  localparam logic [TW-1:0] HIGH_THR_RST = 10'h190;
  localparam logic [TW-1:0] DEV_THR_RST = 10'h00F;
  localparam logic [TW-1:0] UPPER_LIMIT_RST = 10'h2BC;
  localparam logic [TW-1:0] UPPER_LIMIT_MIN = 10'h014;
  localparam logic [TW-1:0] UPPER_LIMIT_MAX = 10'h3E7;
  localparam logic [TW-1:0] SETPOINT_RST = 10'h000;
  localparam logic [6:0] DELAY_RST = 7'h00;
  localparam logic [4:0] ADDR_MAX = 5'h1E;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_GLOBAL = 8'h00;
  localparam logic [7:0] OFS_LIMIT = 8'h04;
  localparam logic [7:0] OFS_DELAY = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_KICK = 8'h10;
  localparam logic [7:0] OFS_SCALE = 8'h14;
  localparam logic [7:0] OFS_ZONE_BASE = 8'h40;
  localparam logic [7:0] OFS_TEMP_BASE = 8'h80;

  // global control field positions
  localparam int GB_MAINS = 0;
  localparam int GB_ENABLE = 1;
  localparam int GB_STBY = 2;
  localparam int GB_TUNE = 3;

  // zone word layout: [9:0] setpoint, [19:10] low, [29:20] high, [31:30] mode
  localparam int ZF_SP = 0;
  localparam int ZF_LO = 10;
  localparam int ZF_HI = 20;
  localparam int ZF_MODE = 30;

  typedef enum logic [1:0] {
    ZAS_MODE_OFF = 2'h0,
    ZAS_MODE_MANUAL = 2'h1,
    ZAS_MODE_AUTO = 2'h2,
    ZAS_MODE_STANDBY = 2'h3
  } zas_mode_e;

  typedef struct packed {
    logic high_lamp;
    logic dev_lamp;
    logic low_lamp;
    logic bus_lamp;
    logic fault_lamp;
    logic fault_relay;
  } zas_ind_s;

  typedef struct packed {
    logic short_monitor_switch;
    logic output_supervision_switch;
    logic temperature_unit_switch;
    logic manual_transfer_switch;
  } zas_cfg_s;
endpackage : zas_pkg

/* File: hw/zas_supervisor.sv */
// zone alarm supervisor: alarms, indicators, fault path, address and globals
//
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module zas_supervisor
  import zas_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // zone side
  input wire logic [ZONES*TW-1:0] temp_i,
  input wire logic [ZONES-1:0] sensor_broken_i,
  input wire logic [4:0] addr_switch_i,
  input wire logic [3:0] cfg_switch_i,
  input wire logic link_up_i,
  input wire logic data_exchange_i,
  input wire logic hw_fault_i,
  input wire logic [ZONES-1:0] heat_req_i,
  input wire logic [ZONES-1:0] cool_req_i,
  output logic [ZONES-1:0] heat_o,
  output logic [ZONES-1:0] cool_o,
  output zas_ind_s ind_o,
  output zas_cfg_s cfg_o,
  output logic [4:0] bus_address_o,
  output logic defaults_restored_o,
  output logic [ZONES-1:0] zone_standby_o,
  output logic tune_start_o,
  output logic mains_frequency_select_o,
  output logic [TW-1:0] upper_temperature_limit_o
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int SW = 5 + 4 + ZONES + 3;
  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  // no reset: the stages fill while reset is held, so the capture after release sees real switches
  always_ff @(posedge clk) begin
    sync1_q <= {addr_switch_i, cfg_switch_i, sensor_broken_i, link_up_i, data_exchange_i, hw_fault_i};
    sync2_q <= sync1_q;
  end
  logic [4:0] addr_sw;
  logic [3:0] cfg_sw;
  logic [ZONES-1:0] broken;
  logic link_up;
  logic dx;
  logic hw_fault;
  assign {addr_sw, cfg_sw, broken, link_up, dx, hw_fault} = sync2_q;

  // temperatures are taken as sampled words from the sensor front end
  logic [ZONES*TW-1:0] temp1_q;
  logic [ZONES*TW-1:0] temp_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      temp1_q <= '0;
      temp_q <= '0;
    end else begin
      temp1_q <= temp_i;
      temp_q <= temp1_q;
    end
  end

  // ----------------------------------------
  // power-up address capture
  // ----------------------------------------
  // switches read once after release; a change needs a new power cycle
  logic started_q;
  logic [4:0] addr_q;
  logic restore;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      started_q <= 1'b0;
      addr_q <= 5'h00;
    end else if (!started_q) begin
      started_q <= 1'b1;
      addr_q <= (addr_sw > ADDR_MAX) ? ADDR_MAX : addr_sw;
    end
  end
  assign restore = !started_q; // one pulse at start, used only when address is zero
  logic restore_hit;
  assign restore_hit = restore && (addr_sw == 5'h00);
  logic restored_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      restored_q <= 1'b0;
    end else if (restore_hit) begin
      restored_q <= 1'b1;
    end
  end
  assign bus_address_o = addr_q;
  assign defaults_restored_o = restored_q;
  assign cfg_o = zas_cfg_s'(cfg_sw);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic req;
  logic wr;
  logic ack_q;
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i && (wb_sel_i == 4'hF);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end
  assign wb_ack_o = ack_q;
  logic [2:0] zidx;
  assign zidx = wb_adr_i[4:2];
  logic zone_sel;
  logic dev_sel;
  assign zone_sel = wb_adr_i[7:5] == OFS_ZONE_BASE[7:5];
  assign dev_sel = wb_adr_i[7:5] == 3'h3; // deviation thresholds at 0x60

  // ----------------------------------------
  // global settings
  // ----------------------------------------
  logic mains_sel_q;
  logic out_en_q;
  logic stby_q;
  logic tune_pend_q;
  logic [TW-1:0] limit_q;
  logic [6:0] delay_q;
  logic [31:0] kick_cnt_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mains_sel_q <= 1'b0;
      out_en_q <= 1'b1;
      stby_q <= 1'b0;
      limit_q <= UPPER_LIMIT_RST;
      delay_q <= DELAY_RST;
    end else if (restore_hit) begin
      mains_sel_q <= 1'b0;
      out_en_q <= 1'b1;
      stby_q <= 1'b0;
      limit_q <= UPPER_LIMIT_RST;
      delay_q <= DELAY_RST;
    end else if (wr && wb_adr_i == OFS_GLOBAL) begin
      mains_sel_q <= wb_dat_i[GB_MAINS];
      out_en_q <= wb_dat_i[GB_ENABLE];
      stby_q <= wb_dat_i[GB_STBY];
    end else if (wr && wb_adr_i == OFS_LIMIT) begin
      // oversize words first, so a value above range never lands on the minimum
      if (wb_dat_i[31:TW] != '0 || wb_dat_i[TW-1:0] > UPPER_LIMIT_MAX) begin
        limit_q <= UPPER_LIMIT_MAX;
      end else if (wb_dat_i[TW-1:0] < UPPER_LIMIT_MIN) begin
        limit_q <= UPPER_LIMIT_MIN;
      end else begin
        limit_q <= wb_dat_i[TW-1:0];
      end
    end else if (wr && wb_adr_i == OFS_DELAY) begin
      delay_q <= (wb_dat_i[31:7] != '0 || wb_dat_i[6:0] > DELAY_MAX_S) ? DELAY_MAX_S : wb_dat_i[6:0];
    end
  end
  assign mains_frequency_select_o = mains_sel_q;
  assign upper_temperature_limit_o = limit_q;

  // tuning request waits for the enable; a new request in the start cycle is kept
  logic tune_req;
  assign tune_req = wr && wb_adr_i == OFS_GLOBAL && wb_dat_i[GB_TUNE];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tune_pend_q <= 1'b0;
    end else if (tune_req) begin
      tune_pend_q <= 1'b1;
    end else if (out_en_q) begin
      tune_pend_q <= 1'b0;
    end
  end
  assign tune_start_o = tune_pend_q && out_en_q;

  // ----------------------------------------
  // per-zone parameters and alarms
  // ----------------------------------------
  logic [ZONES-1:0] low_raw;
  logic [ZONES-1:0] high_raw;
  logic [ZONES-1:0] dev_raw;
  logic [ZONES*TW-1:0] sp_flat;
  logic [ZONES*TW-1:0] lo_flat;
  logic [ZONES*TW-1:0] hi_flat;
  logic [ZONES*TW-1:0] dv_flat;
  logic [ZONES*2-1:0] md_flat;
  genvar g;
  generate
    for (g = 0; g < ZONES; g++) begin : gz
      logic [TW-1:0] sp_q;
      logic [TW-1:0] lo_q;
      logic [TW-1:0] hi_q;
      logic [TW-1:0] dv_q;
      zas_mode_e md_q;
      logic [TW-1:0] t;
      logic [TW-1:0] diff;
      logic wz;
      logic wd;
      assign t = temp_q[g*TW +: TW];
      assign wz = wr && zone_sel && zidx == 3'(g);
      assign wd = wr && dev_sel && zidx == 3'(g);
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          sp_q <= SETPOINT_RST;
          lo_q <= LOW_THR_RST;
          hi_q <= HIGH_THR_RST;
          md_q <= ZAS_MODE_AUTO;
        end else if (restore_hit) begin
          sp_q <= SETPOINT_RST;
          lo_q <= LOW_THR_RST;
          hi_q <= HIGH_THR_RST;
          md_q <= ZAS_MODE_AUTO;
        end else if (wz) begin
          sp_q <= (wb_dat_i[ZF_SP +: TW] > limit_q) ? limit_q : wb_dat_i[ZF_SP +: TW];
          lo_q <= wb_dat_i[ZF_LO +: TW];
          hi_q <= wb_dat_i[ZF_HI +: TW];
          md_q <= zas_mode_e'(wb_dat_i[ZF_MODE +: 2]);
        end else if (sp_q > limit_q) begin
          sp_q <= limit_q;
        end
      end
      // deviation threshold has its own word; zero is raised to one
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          dv_q <= DEV_THR_RST;
        end else if (restore_hit) begin
          dv_q <= DEV_THR_RST;
        end else if (wd) begin
          dv_q <= (wb_dat_i[TW-1:0] == '0) ? 10'h001 : wb_dat_i[TW-1:0];
        end
      end
      assign diff = (t > sp_q) ? (t - sp_q) : (sp_q - t);
      assign low_raw[g] = (sp_q != '0) && (t < lo_q);
      assign high_raw[g] = t > hi_q;
      assign dev_raw[g] = (md_q != ZAS_MODE_OFF) && (diff > dv_q);
      assign zone_standby_o[g] = stby_q || md_q == ZAS_MODE_STANDBY;
      assign sp_flat[g*TW +: TW] = sp_q;
      assign lo_flat[g*TW +: TW] = lo_q;
      assign hi_flat[g*TW +: TW] = hi_q;
      assign dv_flat[g*TW +: TW] = dv_q;
      assign md_flat[g*2 +: 2] = md_q;
    end
  endgenerate

  // ----------------------------------------
  // common alarm delay
  // ----------------------------------------
  // one delay for the alarm set as a whole: the wait restarts whenever the set of raw alarms changes
  logic [3*ZONES-1:0] raw;
  logic [3*ZONES-1:0] raw_q;
  logic [3*ZONES-1:0] rep_q;
  logic [27:0] tick_q;
  logic [6:0] secs_q;
  assign raw = {high_raw, dev_raw, low_raw};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      raw_q <= '0;
      tick_q <= '0;
      secs_q <= '0;
    end else begin
      raw_q <= raw;
      if (raw != raw_q) begin
        tick_q <= '0;
        secs_q <= '0;
      end else if (secs_q < delay_q) begin
        if (tick_q == 28'(SECOND_CYCLES - 1)) begin
          tick_q <= '0;
          secs_q <= secs_q + 7'h01;
        end else begin
          tick_q <= tick_q + 28'h0000001;
        end
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rep_q <= '0;
    end else if (raw == raw_q && secs_q >= delay_q) begin
      rep_q <= raw;
    end
  end
  logic [ZONES-1:0] low_rep;
  logic [ZONES-1:0] dev_rep;
  logic [ZONES-1:0] high_rep;
  assign {high_rep, dev_rep, low_rep} = rep_q;

  // ----------------------------------------
  // watchdog and fault path
  // ----------------------------------------
  // software must write the kick register; silence means the program has stopped
  logic [19:0] wdog_q;
  logic wdog_trip_q;
  logic fault_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdog_q <= '0;
      wdog_trip_q <= 1'b0;
    end else if (wr && wb_adr_i == OFS_KICK) begin
      wdog_q <= '0;
    end else if (wdog_q == 20'(WDOG_CYCLES - 1)) begin
      wdog_trip_q <= 1'b1;
    end else begin
      wdog_q <= wdog_q + 20'h00001;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_q <= 1'b0;
    end else if (hw_fault) begin
      fault_q <= 1'b1;
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      kick_cnt_q <= '0;
    end else if (wr && wb_adr_i == OFS_KICK) begin
      kick_cnt_q <= kick_cnt_q + 32'h00000001;
    end
  end

  // ----------------------------------------
  // outputs and indicators
  // ----------------------------------------
  logic outs_ok;
  assign outs_ok = out_en_q && !fault_q && !wdog_trip_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      heat_o <= '0;
      cool_o <= '0;
      ind_o <= '0;
    end else begin
      heat_o <= outs_ok ? heat_req_i : '0;
      cool_o <= outs_ok ? cool_req_i : '0;
      ind_o.high_lamp <= |high_rep;
      ind_o.dev_lamp <= |dev_rep;
      ind_o.low_lamp <= |low_rep || |broken;
      ind_o.bus_lamp <= link_up && dx;
      ind_o.fault_lamp <= fault_q || wdog_trip_q;
      ind_o.fault_relay <= !fault_q && !wdog_trip_q;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // percentage scaled band: limit * pct / 100, only read back through the scale register
  logic [6:0] pct_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pct_q <= '0;
    end else if (wr && wb_adr_i == OFS_SCALE) begin
      pct_q <= wb_dat_i[6:0];
    end
  end
  logic [16:0] band_prod;
  logic [16:0] band;
  assign band_prod = limit_q * pct_q;
  assign band = band_prod / 17'd100;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_o <= '0;
    end else if (req) begin
      wb_dat_o <= '0;
      if (wb_adr_i == OFS_GLOBAL) begin
        wb_dat_o <= {28'h0, tune_pend_q, stby_q, out_en_q, mains_sel_q};
      end else if (wb_adr_i == OFS_LIMIT) begin
        wb_dat_o <= {22'h0, limit_q};
      end else if (wb_adr_i == OFS_DELAY) begin
        wb_dat_o <= {25'h0, delay_q};
      end else if (wb_adr_i == OFS_STATUS) begin
        wb_dat_o <= {restored_q, wdog_trip_q, fault_q, addr_q, rep_q};
      end else if (wb_adr_i == OFS_KICK) begin
        wb_dat_o <= kick_cnt_q;
      end else if (wb_adr_i == OFS_SCALE) begin
        wb_dat_o <= {8'h0, band[15:0], 1'b0, pct_q};
      end else if (zone_sel) begin
        wb_dat_o <= {md_flat[zidx*2 +: 2], hi_flat[zidx*TW +: TW], lo_flat[zidx*TW +: TW], sp_flat[zidx*TW +: TW]};
      end else if (dev_sel) begin
        wb_dat_o <= {22'h0, dv_flat[zidx*TW +: TW]};
      end else if (wb_adr_i[7:5] == OFS_TEMP_BASE[7:5]) begin
        wb_dat_o <= {22'h0, temp_q[zidx*TW +: TW]};
      end
    end
  end
endmodule : zas_supervisor
`default_nettype wire

/* File: test/zas_fb_master.sv */
// partner model: fieldbus-side master issuing classic wishbone cycles
`timescale 1ns/1ps
`default_nettype none
module zas_fb_master
  import zas_pkg::*;
(
  input wire logic clk,
  output var logic cyc,
  output var logic stb,
  output var logic we,
  output var logic [7:0] adr,
  output var logic [3:0] sel,
  output var logic [31:0] dat,
  input wire logic ack,
  input wire logic [31:0] rdat
);
  // idle bus at time zero
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h0;
  end
  // one cycle: held until ack is sampled; address and data invert on release so stale data never looks valid
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    adr <= ~a;
    dat <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
endmodule // zas_fb_master
`default_nettype wire

/* File: test/zas_sup_monitor.sv */
// checker: handshake, fault path, lamps and switch capture of the supervisor
`timescale 1ns/1ps
`default_nettype none
module zas_sup_monitor
  import zas_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic [3:0] cfg_switch_i,
  input wire logic link_up_i,
  input wire logic data_exchange_i,
  input wire logic hw_fault_i,
  input wire logic [ZONES-1:0] heat_req_i,
  input wire logic [ZONES-1:0] cool_req_i,
  input wire logic [ZONES-1:0] heat_o,
  input wire logic [ZONES-1:0] cool_o,
  input wire zas_ind_s ind_o,
  input wire zas_cfg_s cfg_o,
  input wire logic [4:0] bus_address_o,
  input wire logic defaults_restored_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ------
  // edges since release; before that $past still reaches back into the reset phase
  // ------
  logic [1:0] up_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) up_q <= 2'h0;
    else if (up_q != 2'h3) up_q <= up_q + 2'h1;
  end
  sequence s_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_link;
    (link_up_i && data_exchange_i) [*5];
  endsequence
  // ------
  // properties
  // ------
  AST_ACK_NEXT: assert property (s_taken |=> wb_ack_o)
    else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_FAULT_LAMP: assert property (hw_fault_i [*4] |-> ##[0:4] ind_o.fault_lamp)
    else $error("fault lamp not lit");
  AST_FAULT_OUT: assert property (ind_o.fault_lamp |-> ##1 (!ind_o.fault_relay && heat_o == 8'h00 && cool_o == 8'h00))
    else $error("outputs or relay not dropped on fault");
  AST_RELAY_OUT: assert property (!ind_o.fault_relay [*2] |-> heat_o == 8'h00 && cool_o == 8'h00)
    else $error("outputs live with fault relay open");
  AST_OUT_SUBSET: assert property ((heat_o & ~$past(heat_req_i)) == 8'h00 && (cool_o & ~$past(cool_req_i)) == 8'h00)
    else $error("output on without request");
  AST_BUS_ON: assert property (s_link |-> ind_o.bus_lamp)
    else $error("bus lamp dark in exchange");
  AST_BUS_OFF: assert property (!link_up_i [*4] |=> !ind_o.bus_lamp)
    else $error("bus lamp lit without link");
  AST_ADDR_MAX: assert property (bus_address_o <= ADDR_MAX)
    else $error("bus address above limit");
  AST_RESTORED: assert property (defaults_restored_o |-> bus_address_o == 5'h00)
    else $error("restore flagged with nonzero address");
  AST_CFG_SYNC: assert property (up_q == 2'h3 |-> cfg_o == zas_cfg_s'($past(cfg_switch_i, 2)))
    else $error("switch settings not passed through");
endmodule // zas_sup_monitor
bind zas_supervisor zas_sup_monitor i_mon (.clk(clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .cfg_switch_i(cfg_switch_i), .link_up_i(link_up_i), .data_exchange_i(data_exchange_i),
  .hw_fault_i(hw_fault_i), .heat_req_i(heat_req_i), .cool_req_i(cool_req_i), .heat_o(heat_o), .cool_o(cool_o),
  .ind_o(ind_o), .cfg_o(cfg_o), .bus_address_o(bus_address_o), .defaults_restored_o(defaults_restored_o));
`default_nettype wire

/* File: test/zas_supervisor_tb.sv */
// testbench: registers, alarms, globals, fault path and address capture
`timescale 1ns/1ps
`default_nettype none
module zas_supervisor_tb
  import zas_pkg::*;
;
  localparam int Z = 5;
  localparam logic [7:0] ZA = 8'h54;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [ZONES*TW-1:0] temp = '0;
  logic [7:0] broken = 8'h00, hreq = 8'hA5, creq = 8'h3C;
  logic [4:0] addr_sw = 5'h06;
  logic [3:0] cfg_sw = 4'h0;
  logic link = 1'b0, exch = 1'b0, fault = 1'b0, tune_seen = 1'b0;
  logic cyc, stb, we, ack, rest, tune, mains;
  logic [7:0] adr, heat, cool, stby;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, v;
  logic [4:0] baddr;
  logic [9:0] lim;
  zas_ind_s ind;
  zas_cfg_s cfg;
  int num_errors = 0, compares = 0, cycles = 0;
  logic [31:0] lw[5] = '{32'h5, 32'h3FF, 32'h400, 32'h14, 32'h1F4};
  logic [31:0] le[5] = '{32'h14, 32'h3E7, 32'h3E7, 32'h14, 32'h1F4};
  always #2 clk = ~clk;
  zas_fb_master i_master (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel), .dat(wdat),
    .ack(ack), .rdat(rdat));
  zas_supervisor i_dut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .temp_i(temp),
    .sensor_broken_i(broken), .addr_switch_i(addr_sw), .cfg_switch_i(cfg_sw), .link_up_i(link),
    .data_exchange_i(exch), .hw_fault_i(fault), .heat_req_i(hreq), .cool_req_i(creq), .heat_o(heat),
    .cool_o(cool), .ind_o(ind), .cfg_o(cfg), .bus_address_o(baddr), .defaults_restored_o(rest),
    .zone_standby_o(stby), .tune_start_o(tune), .mains_frequency_select_o(mains),
    .upper_temperature_limit_o(lim));
  // ------
  // checking and closing
  // ------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard and tune pulse catcher; a pulse is too short to poll over the bus
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (tune) tune_seen <= 1'b1;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  // switches held through the whole reset so the capture sees settled values
  task automatic do_reset(input logic [4:0] a);
    resetn <= 1'b0;
    addr_sw <= a;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask
  // one zone setting and temperature, then reported alarms {high,dev,low}
  task automatic alarm(input logic [1:0] m, input logic [9:0] sp, input logic [9:0] t, input logic [2:0] e);
    i_master.wr(ZA, {m, 10'h0C8, 10'h032, sp});
    temp[Z*TW +: TW] <= t;
    repeat (12) @(posedge clk);
    i_master.rd(OFS_STATUS, v);
    check("alarm status", v[23:0], (32'(e[2]) << (16 + Z)) | (32'(e[1]) << (8 + Z)) | (32'(e[0]) << Z));
    check("alarm lamps", {ind.high_lamp, ind.dev_lamp, ind.low_lamp}, e);
  endtask
  // ------
  // main sequence
  // ------
  initial begin
    do_reset(5'h06);
    check("address", baddr, 5'h06);
    check("relay", ind.fault_relay, 1'b1);
    check("heat", heat, 8'hA5);
    check("cool", cool, 8'h3C);
    foreach (lw[i]) begin
      i_master.wr(OFS_LIMIT, lw[i]);
      i_master.rd(OFS_LIMIT, v);
      check("limit", v, le[i]);
    end
    check("limit out", lim, 10'h1F4);
    i_master.wr(ZA, {2'h2, 10'h0C8, 10'h032, 10'h258});
    i_master.rd(ZA, v);
    check("setpoint clamp", v[9:0], 10'h1F4);
    i_master.wr(OFS_SCALE, 32'hA);
    i_master.rd(OFS_SCALE, v);
    check("scaled", v[23:8], 16'h0032);
    i_master.wr(OFS_DELAY, 32'h64);
    i_master.rd(OFS_DELAY, v);
    check("delay clamp", v, 32'h5A);
    i_master.wr(8'h74, 32'h14);
    i_master.wr(OFS_DELAY, 32'h0);
    alarm(2'h2, 10'h064, 10'h064, 3'b000);
    alarm(2'h2, 10'h064, 10'h02D, 3'b011);
    alarm(2'h2, 10'h064, 10'h078, 3'b000);
    alarm(2'h2, 10'h064, 10'h079, 3'b010);
    alarm(2'h2, 10'h064, 10'h04F, 3'b010);
    alarm(2'h2, 10'h064, 10'h0C9, 3'b110);
    alarm(2'h0, 10'h064, 10'h082, 3'b000);
    alarm(2'h0, 10'h064, 10'h02D, 3'b001);
    alarm(2'h0, 10'h000, 10'h02D, 3'b000);
    alarm(2'h0, 10'h000, 10'h0FA, 3'b100);
    alarm(2'h2, 10'h064, 10'h064, 3'b000);
    broken <= 8'h08;
    repeat (8) @(posedge clk);
    check("broken lamp", ind.low_lamp, 1'b1);
    broken <= 8'h00;
    // one second of hold-off is far beyond the run, so only the hold is seen
    i_master.wr(OFS_DELAY, 32'h1);
    temp[Z*TW +: TW] <= 10'h0C9;
    repeat (50) @(posedge clk);
    i_master.rd(OFS_STATUS, v);
    check("held alarm", v[23:0], 24'h0);
    i_master.rd(8'h94, v);
    check("zone temp", v, 32'hC9);
    i_master.wr(OFS_DELAY, 32'h0);
    alarm(2'h2, 10'h064, 10'h0C9, 3'b110);
    alarm(2'h3, 10'h064, 10'h064, 3'b000);
    check("zone standby", stby, 8'h20);
    i_master.wr(ZA, {2'h2, 10'h0C8, 10'h032, 10'h064});
    i_master.wr(OFS_GLOBAL, 32'h3);
    check("mains", mains, 1'b1);
    i_master.wr(OFS_GLOBAL, 32'h6);
    check("standby", stby, 8'hFF);
    tune_seen = 1'b0;
    i_master.wr(OFS_GLOBAL, 32'h8);
    repeat (4) @(posedge clk);
    check("heat off", heat, 8'h00);
    check("cool off", cool, 8'h00);
    i_master.rd(OFS_GLOBAL, v);
    check("tune pending", v[3:0], 4'h8);
    check("tune held", tune_seen, 1'b0);
    i_master.wr(OFS_GLOBAL, 32'h2);
    repeat (4) @(posedge clk);
    check("tune started", tune_seen, 1'b1);
    check("heat back", heat, 8'hA5);
    check("standby off", stby, 8'h00);
    for (int i = 0; i < 4; i++) begin
      {link, exch} <= 2'(i);
      repeat (6) @(posedge clk);
      check("bus lamp", ind.bus_lamp, i == 3);
    end
    for (int i = 0; i < 2; i++) begin
      cfg_sw <= 4'hA ^ {4{i[0]}};
      repeat (4) @(posedge clk);
      check("switches", cfg, 4'hA ^ {4{i[0]}});
    end
    i_master.rd(8'h3C, v);
    check("unmapped", v, 32'h0);
    i_master.wr(OFS_STATUS, 32'hFFFFFFFF);
    i_master.rd(OFS_STATUS, v);
    check("status flags", v[31:24], 8'h06);
    i_master.wr(OFS_KICK, 32'h1);
    i_master.rd(OFS_KICK, v);
    check("kicks", v, 32'h1);
    fault <= 1'b1;
    repeat (8) @(posedge clk);
    check("fault lamp", ind.fault_lamp, 1'b1);
    check("fault relay", ind.fault_relay, 1'b0);
    check("fault heat", heat | cool, 8'h00);
    i_master.rd(OFS_STATUS, v);
    check("fault status", v[29], 1'b1);
    fault <= 1'b0;
    do_reset(5'h00);
    check("restored", rest, 1'b1);
    i_master.rd(ZA, v);
    check("zone defaults", v, {2'h2, HIGH_THR_RST, LOW_THR_RST, SETPOINT_RST});
    i_master.rd(OFS_GLOBAL, v);
    check("global defaults", v, 32'h2);
    i_master.rd(OFS_LIMIT, v);
    check("limit default", v, 32'h2BC);
    i_master.rd(8'h74, v);
    check("dev default", v, 32'hF);
    do_reset(5'h1F);
    check("address clamp", baddr, 5'h1E);
    do_reset(5'h06);
    check("normal start", {rest, baddr}, 6'h06);
    summarize();
  end
endmodule // zas_supervisor_tb
`default_nettype wire
